// File: shared/emx_pkg.sv
// Purpose: Shared constants and types for the extended memory instruction tail.
// Assumes: 8-bit data path, program words of 16 bits.
// Notes:   Flag reset values and cycle counts are held here once.
package emx_pkg;

    // Operations handled by this execution block
    typedef enum logic [3:0] {
        EMX_OP_NONE       = 4'h0,
        EMX_OP_SUB_ACC    = 4'h1, // long_subtract_to_acc
        EMX_OP_SUB_MEM    = 4'h2, // long_subtract_to_mem
        EMX_OP_SWAP_MEM   = 4'h3, // nibble_swap_in_place
        EMX_OP_SWAP_ACC   = 4'h4, // nibble_swap_to_acc
        EMX_OP_SKIP_Z     = 4'h5, // skip_if_zero
        EMX_OP_MOV_SKIP_Z = 4'h6, // move_and_skip_if_zero
        EMX_OP_SKIP_NZ    = 4'h7, // skip_if_nonzero
        EMX_OP_SKIP_BIT_Z = 4'h8, // bit-test skip when bit clear
        EMX_OP_TRD_CUR    = 4'h9, // table_read_current_page
        EMX_OP_TRD_LAST   = 4'hA, // table_read_last_page
        EMX_OP_TRD_INC    = 4'hB, // preinc_table_read
        EMX_OP_TRD_INC_LP = 4'hC, // preinc_table_read_last_page
        EMX_OP_XOR_ACC    = 4'hD, // xor_to_acc
        EMX_OP_XOR_MEM    = 4'hE  // xor_to_mem
    } emx_op_t;

    // Sequencer states, Gray coded along idle -> request -> capture
    typedef enum logic [1:0] {
        EMX_IDLE  = 2'b00,
        EMX_REQ   = 2'b01,
        EMX_CAP   = 2'b11,
        EMX_DUMMY = 2'b10
    } emx_state_t;

    localparam logic [7:0] EMX_ACC_RST  = 8'h00;
    localparam logic [7:0] EMX_TP_RST   = 8'h00;
    localparam logic [7:0] EMX_TBH_RST  = 8'h00;
    localparam logic       EMX_FLAG_RST = 1'b0;
    // Cycles the block is busy after a taken skip and after a table read
    localparam int         EMX_SKIP_BUSY = 1;
    localparam int         EMX_TRD_BUSY  = 2;

endpackage

// File: rtl/emx_sub.sv
// Purpose: Byte subtractor with the full flag set of the subtract group.
// Assumes: Purely combinational; caller registers the results.
// Notes:   Carry reads as "no borrow", so it is set for a zero or positive difference.
`timescale 1ns/1ps
module emx_sub
    import emx_pkg::*;
(
    input  wire logic [7:0] a,
    input  wire logic [7:0] b,
    output logic      [7:0] diff,
    output logic            c,
    output logic            ac,
    output logic            ov,
    output logic            z,
    output logic            sc,
    output logic            cz
);
    logic [8:0] full;
    logic [4:0] low;

    // Nine-bit difference exposes the borrow out of bit 7
    assign full = {1'b0, a} - {1'b0, b};
    assign low  = {1'b0, a[3:0]} - {1'b0, b[3:0]};
    assign diff = full[7:0];
    assign c    = ~full[8];
    assign ac   = ~low[4];
    // Signed overflow when operand signs differ and result sign follows b
    assign ov   = (a[7] ^ b[7]) & (a[7] ^ full[7]);
    assign z    = (full[7:0] == 8'h00);
    // Signed compare: set when a >= b as signed numbers
    assign sc   = ~(ov ^ full[7]);
    // No carry-in here, so the combined zero equals the plain zero
    assign cz   = (full[7:0] == 8'h00);
endmodule

// File: rtl/emx_exec.sv
// Purpose: Executes the subtract, swap, skip, table read and XOR instructions.
// Assumes: Operand byte arrives with op_valid; program memory answers one cycle after prog_req.
// Notes:   Accumulator, flags and table pointers live here; core loads accumulator and table pointers via *_we ports.
`timescale 1ns/1ps
// Function
// RQ1 - Subtract to accumulator: acc minus memory byte, all six arithmetic flags updated.
// RQ2 - Carry clears on negative difference, sets on zero or positive.
// RQ3 - Subtract to memory: same difference and flags, stored into the memory byte.
// RQ4 - Swap in place exchanges nibbles of memory byte, flags untouched.
// RQ5 - Swap to accumulator loads swapped byte, memory and flags untouched.
// RQ6 - Zero-test skip skips next instruction when byte is zero, no flags.
// RQ7 - Any taken skip adds one dummy cycle, so skips take two cycles.
// RQ8 - Move-and-skip copies byte to accumulator, skips if zero, no flags.
// RQ9 - Bit-test skip skips when the selected bit is zero.
// RQ10 - Current-page table read: low byte to memory, high byte to latch.
// RQ11 - Last-page table read: same split, address in the last page.
// RQ12 - Pre-increment read bumps pointer low, then reads at full pointer.
// RQ13 - Pre-increment last-page read bumps pointer low, reads last page, no flags.
// RQ14 - XOR to accumulator stores result in accumulator, updates zero flag only.
// RQ15 - XOR to memory stores result in memory byte, updates zero flag only.
// RQ16 - Nonzero-test skip skips when byte is nonzero, two cycles when skipping.
// RQ17 - Non-skip, non-table operations finish in one cycle, results at its end.
module emx_exec
    import emx_pkg::*;
#(
    parameter int DA_W = 9,   // Data memory address width
    parameter int PA_W = 14   // Program memory address width
) (
    input  wire logic            mclk,
    input  wire logic            rst_n,
    input  wire logic            op_valid,
    input  wire emx_op_t         op_code,
    input  wire logic [DA_W-1:0] op_addr,
    input  wire logic [2:0]      bit_sel,
    input  wire logic [7:0]      mem_rdata,
    input  wire logic [15:0]     prog_rdata,
    input  wire logic [PA_W-9:0] pc_page,
    input  wire logic            acc_we,
    input  wire logic [7:0]      acc_wdata,
    input  wire logic            tp_low_we,
    input  wire logic            tp_high_we,
    input  wire logic [7:0]      tp_wdata,
    output logic                 op_ready,
    output logic                 mem_we,
    output logic [DA_W-1:0]      mem_addr,
    output logic [7:0]           mem_wdata,
    output logic                 prog_req,
    output logic [PA_W-1:0]      prog_addr,
    output logic                 skip,
    output logic [7:0]           accumulator,
    output logic                 overflow_flag,
    output logic                 zero_flag,
    output logic                 aux_carry_flag,
    output logic                 carry_flag,
    output logic                 signed_compare_flag,
    output logic                 combined_zero_flag,
    output logic [7:0]           table_pointer_low,
    output logic [7:0]           table_pointer_high,
    output logic [7:0]           table_high_latch
);
    // Elaboration check: page field needs at least one bit, pointer at most 16
    if (PA_W < 9 || PA_W > 16 || DA_W < 1) begin : g_chk
        $error("emx_exec: unsupported address widths");
    end

    emx_state_t state;
    emx_state_t next_state;
    logic [7:0] sub_diff;
    logic       sub_c, sub_ac, sub_ov, sub_z, sub_sc, sub_cz;
    logic [7:0] swapped;
    logic [7:0] xor_res;
    logic [7:0] tp_inc;
    logic       take;
    logic       skip_cond;
    logic       is_trd;
    logic       is_sub;
    logic       is_xor;

    emx_sub u_sub (
        .a    (accumulator),
        .b    (mem_rdata),
        .diff (sub_diff),
        .c    (sub_c),
        .ac   (sub_ac),
        .ov   (sub_ov),
        .z    (sub_z),
        .sc   (sub_sc),
        .cz   (sub_cz)
    );

    // Operand decode shared by several processes
    assign take    = op_valid & op_ready;
    assign swapped = {mem_rdata[3:0], mem_rdata[7:4]};
    assign xor_res = accumulator ^ mem_rdata;
    assign tp_inc  = table_pointer_low + 8'h01;
    assign is_sub  = (op_code == EMX_OP_SUB_ACC) || (op_code == EMX_OP_SUB_MEM);
    assign is_xor  = (op_code == EMX_OP_XOR_ACC) || (op_code == EMX_OP_XOR_MEM);
    assign is_trd  = (op_code == EMX_OP_TRD_CUR) || (op_code == EMX_OP_TRD_LAST)
                  || (op_code == EMX_OP_TRD_INC) || (op_code == EMX_OP_TRD_INC_LP);

    // Skip conditions for all four skip forms
    always_comb begin
        unique case (op_code)
            // RQ6 zero test
            EMX_OP_SKIP_Z:     skip_cond = (mem_rdata == 8'h00);
            // RQ8 move and test
            EMX_OP_MOV_SKIP_Z: skip_cond = (mem_rdata == 8'h00);
            // RQ16 nonzero test
            EMX_OP_SKIP_NZ:    skip_cond = (mem_rdata != 8'h00);
            // RQ9 bit test
            EMX_OP_SKIP_BIT_Z: skip_cond = ~mem_rdata[bit_sel];
            default:           skip_cond = 1'b0;
        endcase
    end

    // Ready only while idle; a busy core holds the next instruction
    // RQ17 ready when idle
    assign op_ready = (state == EMX_IDLE);

    // Sequencer: table reads need request and capture, taken skips a dummy cycle
    always_comb begin
        next_state = state;
        unique case (state)
            EMX_IDLE: begin
                if (take && is_trd) begin
                    next_state = EMX_REQ;
                // RQ7 insert dummy cycle
                end else if (take && skip_cond) begin
                    next_state = EMX_DUMMY;
                end
            end
            EMX_REQ:   next_state = EMX_CAP;
            EMX_CAP:   next_state = EMX_IDLE;
            EMX_DUMMY: next_state = EMX_IDLE;
        endcase
    end

    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            state <= EMX_IDLE;
        end else begin
            state <= next_state;
        end
    end

    // Skip pulse is registered so the fetch unit sees it with the dummy cycle
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            skip <= 1'b0;
        end else begin
            skip <= take & skip_cond;
        end
    end

    // Accumulator: core loads win only when no instruction writes it
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            accumulator <= EMX_ACC_RST;
        end else if (take && op_code == EMX_OP_SUB_ACC) begin
            // RQ1 difference to acc
            accumulator <= sub_diff;
        end else if (take && op_code == EMX_OP_SWAP_ACC) begin
            // RQ5 swapped to acc
            accumulator <= swapped;
        end else if (take && op_code == EMX_OP_MOV_SKIP_Z) begin
            // RQ8 copy to acc
            accumulator <= mem_rdata;
        end else if (take && op_code == EMX_OP_XOR_ACC) begin
            // RQ14 xor to acc
            accumulator <= xor_res;
        end else if (acc_we) begin
            accumulator <= acc_wdata;
        end
    end

    // Arithmetic flags; swaps, skips and table reads leave them alone
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            overflow_flag       <= EMX_FLAG_RST;
            zero_flag           <= EMX_FLAG_RST;
            aux_carry_flag      <= EMX_FLAG_RST;
            carry_flag          <= EMX_FLAG_RST;
            signed_compare_flag <= EMX_FLAG_RST;
            combined_zero_flag  <= EMX_FLAG_RST;
        end else if (take && is_sub) begin
            // RQ1 RQ3 subtract flags
            overflow_flag       <= sub_ov;
            zero_flag           <= sub_z;
            aux_carry_flag      <= sub_ac;
            // RQ2 carry is no-borrow
            carry_flag          <= sub_c;
            signed_compare_flag <= sub_sc;
            combined_zero_flag  <= sub_cz;
        end else if (take && is_xor) begin
            // RQ14 RQ15 zero only
            zero_flag <= (xor_res == 8'h00);
        end
    end

    // Memory write port; table reads write in the capture cycle
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            mem_we    <= 1'b0;
            mem_addr  <= '0;
            mem_wdata <= 8'h00;
        end else begin
            mem_we <= 1'b0;
            if (take) begin
                mem_addr <= op_addr; // Held for the table read capture
            end
            if (take && op_code == EMX_OP_SUB_MEM) begin
                // RQ3 difference to memory
                mem_we    <= 1'b1;
                mem_wdata <= sub_diff;
            end else if (take && op_code == EMX_OP_SWAP_MEM) begin
                // RQ4 swap in place
                mem_we    <= 1'b1;
                mem_wdata <= swapped;
            end else if (take && op_code == EMX_OP_XOR_MEM) begin
                // RQ15 xor to memory
                mem_we    <= 1'b1;
                mem_wdata <= xor_res;
            end else if (state == EMX_CAP) begin
                // RQ10 RQ11 low byte out
                mem_we    <= 1'b1;
                mem_wdata <= prog_rdata[7:0];
            end
        end
    end

    // Table pointers: pre-increment happens on acceptance, before the fetch
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            table_pointer_low  <= EMX_TP_RST;
            table_pointer_high <= EMX_TP_RST;
        end else begin
            // RQ12 RQ13 increment first
            if (take && (op_code == EMX_OP_TRD_INC || op_code == EMX_OP_TRD_INC_LP)) begin
                table_pointer_low <= tp_inc;
            end else if (tp_low_we) begin
                table_pointer_low <= tp_wdata;
            end
            if (tp_high_we) begin
                table_pointer_high <= tp_wdata;
            end
        end
    end

    // Program address formed from the pointer value the fetch must use
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            prog_req  <= 1'b0;
            prog_addr <= '0;
        end else begin
            prog_req <= take & is_trd;
            if (take) begin
                unique case (op_code)
                    // RQ10 current page
                    EMX_OP_TRD_CUR:    prog_addr <= {pc_page, table_pointer_low};
                    // RQ11 last page
                    EMX_OP_TRD_LAST:   prog_addr <= {{(PA_W-8){1'b1}}, table_pointer_low};
                    // RQ12 full pointer
                    EMX_OP_TRD_INC: begin
                        prog_addr <= PA_W'({table_pointer_high, tp_inc});
                    end
                    // RQ13 last page after increment
                    EMX_OP_TRD_INC_LP: prog_addr <= {{(PA_W-8){1'b1}}, tp_inc};
                    default:           prog_addr <= prog_addr;
                endcase
            end
        end
    end

    // High byte of the fetched word; a hazard-free load since the core is stalled
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            table_high_latch <= EMX_TBH_RST;
        end else if (state == EMX_CAP) begin
            // RQ10 RQ11 high byte latch
            table_high_latch <= prog_rdata[15:8];
        end
    end

    // Checks kept next to the logic they watch
    default clocking cb @(posedge mclk);
    endclocking
    default disable iff (!rst_n);

    sequence trd_accept_s;
        op_valid && op_ready && is_trd;
    endsequence

    // Write lands at the end of the capture cycle, as ready returns
    sequence trd_finish_s;
        prog_req && !op_ready ##1 !op_ready && !mem_we ##1 mem_we && op_ready;
    endsequence

    sub_acc_result_a: assert property ( // RQ1
        op_valid && op_ready && op_code == EMX_OP_SUB_ACC
        |=> accumulator == $past(accumulator) - $past(mem_rdata))
        else $error("subtract to accumulator result wrong");

    sub_carry_a: assert property ( // RQ2
        op_valid && op_ready && is_sub
        |=> carry_flag == ($past(accumulator) >= $past(mem_rdata)))
        else $error("subtract carry does not track borrow");

    sub_mem_a: assert property ( // RQ3
        op_valid && op_ready && op_code == EMX_OP_SUB_MEM
        |=> mem_we && mem_wdata == $past(accumulator) - $past(mem_rdata))
        else $error("subtract to memory write wrong");

    swap_flags_a: assert property ( // RQ4
        op_valid && op_ready && op_code == EMX_OP_SWAP_MEM
        |=> mem_we && $stable(carry_flag) && $stable(zero_flag))
        else $error("swap in place disturbed flags or skipped write");

    swap_acc_a: assert property ( // RQ5
        op_valid && op_ready && op_code == EMX_OP_SWAP_ACC
        |=> !mem_we && accumulator == {$past(mem_rdata[3:0]), $past(mem_rdata[7:4])})
        else $error("swap to accumulator wrong");

    skip_dummy_a: assert property ( // RQ7
        skip |-> !op_ready ##1 op_ready)
        else $error("taken skip lacks exactly one dummy cycle");

    skip_zero_a: assert property ( // RQ6
        op_valid && op_ready && op_code == EMX_OP_SKIP_Z
        |=> skip == ($past(mem_rdata) == 8'h00))
        else $error("zero-test skip decision wrong");

    skip_nz_a: assert property ( // RQ16
        op_valid && op_ready && op_code == EMX_OP_SKIP_NZ && mem_rdata != 8'h00
        |=> skip && !op_ready ##1 op_ready)
        else $error("nonzero skip not taken in two cycles");

    trd_sequence_a: assert property ( // RQ10
        trd_accept_s |=> trd_finish_s)
        else $error("table read did not complete in three cycles");

    xor_zero_a: assert property ( // RQ14
        op_valid && op_ready && op_code == EMX_OP_XOR_ACC
        |=> zero_flag == (accumulator == 8'h00) && $stable(carry_flag))
        else $error("xor zero flag wrong");

    single_cycle_a: assert property ( // RQ17
        op_valid && op_ready && !is_trd && !skip_cond |=> op_ready)
        else $error("single cycle operation stalled");

endmodule

// File: bench/emx_exec_tb.sv
// Purpose: Self-checking bench for the extended memory instruction tail.
// Assumes: Default widths (9-bit data address, 14-bit program address).
// Notes:   Design assertions sit in the design; this bench judges the ports only.
`timescale 1ns/1ps
module testbench;
    import emx_pkg::*;

    logic        mclk;
    logic        rst_n;
    logic        op_valid;
    emx_op_t     op_code;
    logic [8:0]  op_addr;
    logic [2:0]  bit_sel;
    logic [7:0]  mem_rdata;
    logic [15:0] prog_rdata;
    logic [5:0]  pc_page;
    logic        acc_we;
    logic [7:0]  acc_wdata;
    logic        tp_low_we;
    logic        tp_high_we;
    logic [7:0]  tp_wdata;
    logic        op_ready;
    logic        mem_we;
    logic [8:0]  mem_addr;
    logic [7:0]  mem_wdata;
    logic        prog_req;
    logic [13:0] prog_addr;
    logic        skip;
    logic [7:0]  accumulator;
    logic        ov;
    logic        zf;
    logic        ac;
    logic        cf;
    logic        sc;
    logic        cz;
    logic [7:0]  tp_low;
    logic [7:0]  tp_high;
    logic [7:0]  tb_latch;
    int          err_count;
    int          n_checks;

    emx_exec dut (
        .mclk(mclk), .rst_n(rst_n), .op_valid(op_valid), .op_code(op_code),
        .op_addr(op_addr), .bit_sel(bit_sel), .mem_rdata(mem_rdata),
        .prog_rdata(prog_rdata), .pc_page(pc_page), .acc_we(acc_we),
        .acc_wdata(acc_wdata), .tp_low_we(tp_low_we), .tp_high_we(tp_high_we),
        .tp_wdata(tp_wdata), .op_ready(op_ready), .mem_we(mem_we),
        .mem_addr(mem_addr), .mem_wdata(mem_wdata), .prog_req(prog_req),
        .prog_addr(prog_addr), .skip(skip), .accumulator(accumulator),
        .overflow_flag(ov), .zero_flag(zf), .aux_carry_flag(ac), .carry_flag(cf),
        .signed_compare_flag(sc), .combined_zero_flag(cz),
        .table_pointer_low(tp_low), .table_pointer_high(tp_high),
        .table_high_latch(tb_latch)
    );

    // Free-running 250 MHz clock
    initial begin
        mclk = 1'b0;
        forever #2 mclk = ~mclk;
    end

    task automatic complete_run();
        $display("checks %0d mismatches %0d", n_checks, err_count);
        if (err_count == 0 && n_checks > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask

    task automatic cmp_bit(input logic got, input logic exp, input string what);
        n_checks++;
        if (got !== exp) begin
            err_count++;
            $display("CHECK FAILED t=%0t %s got %b exp %b", $time, what, got, exp);
        end
    endtask

    task automatic cmp_val(input logic [15:0] got, input logic [15:0] exp, input string what);
        n_checks++;
        if (got !== exp) begin
            err_count++;
            $display("CHECK FAILED t=%0t %s got %h exp %h", $time, what, got, exp);
        end
    endtask

    // Flag order: overflow, zero, aux carry, carry, signed compare, combined zero
    task automatic cmp_flags(input logic [5:0] exp);
        n_checks++;
        if ({ov, zf, ac, cf, sc, cz} !== exp) begin
            err_count++;
            $display("CHECK FAILED t=%0t flags got %b exp %b", $time,
                     {ov, zf, ac, cf, sc, cz}, exp);
        end
    endtask

    // One instruction; returns 1 ns into the cycle after the taking edge
    task automatic issue(input emx_op_t op, input logic [7:0] d, input logic [2:0] b);
        @(posedge mclk);
        op_valid  <= 1'b1;
        op_code   <= op;
        mem_rdata <= d;
        bit_sel   <= b;
        op_addr   <= 9'h1A5;
        @(posedge mclk);
        op_valid  <= 1'b0;
        mem_rdata <= ~d;    // Stale operand is inverted so a late sample shows
        #1;
    endtask

    task automatic load(input logic [7:0] acc, input logic [7:0] lo, input logic [7:0] hi);
        @(posedge mclk);
        acc_we     <= 1'b1;
        acc_wdata  <= acc;
        tp_low_we  <= 1'b1;
        tp_high_we <= 1'b1;
        tp_wdata   <= lo;
        @(posedge mclk);
        acc_we     <= 1'b0;
        tp_low_we  <= 1'b0;
        tp_wdata   <= hi;
        @(posedge mclk);
        tp_high_we <= 1'b0;
        tp_low_we  <= 1'b0;
        #1;
    endtask

    task automatic t_subtract();
        load(8'h10, 8'h00, 8'h00);
        issue(EMX_OP_SUB_ACC, 8'h20, 3'h0);
        cmp_val(accumulator, 16'h00F0, "sub acc");
        cmp_flags(6'b001000);
        load(8'h80, 8'h00, 8'h00);
        issue(EMX_OP_SUB_ACC, 8'h01, 3'h0);
        cmp_val(accumulator, 16'h007F, "sub ovf");
        cmp_flags(6'b100100);
        issue(EMX_OP_SUB_MEM, 8'h7F, 3'h0);
        cmp_bit(mem_we, 1'b1, "sub mem we");
        cmp_val(mem_wdata, 16'h0000, "sub mem data");
        cmp_val(mem_addr, 16'h01A5, "sub mem addr");
        cmp_val(accumulator, 16'h007F, "acc kept");
        cmp_flags(6'b011111);
    endtask

    task automatic t_swap_xor();
        issue(EMX_OP_SWAP_MEM, 8'h3C, 3'h0);
        cmp_val(mem_wdata, 16'h00C3, "swap mem");
        cmp_flags(6'b011111);
        issue(EMX_OP_SWAP_ACC, 8'h5A, 3'h0);
        cmp_val(accumulator, 16'h00A5, "swap acc");
        cmp_bit(mem_we, 1'b0, "swap acc no write");
        cmp_flags(6'b011111);
        issue(EMX_OP_XOR_ACC, 8'hAA, 3'h0);
        cmp_val(accumulator, 16'h000F, "xor acc");
        cmp_flags(6'b001111);
        issue(EMX_OP_XOR_MEM, 8'h0F, 3'h0);
        cmp_bit(mem_we, 1'b1, "xor mem we");
        cmp_val(mem_wdata, 16'h0000, "xor mem");
        cmp_val(accumulator, 16'h000F, "xor acc kept");
        cmp_flags(6'b011111);
        cmp_bit(op_ready, 1'b1, "single cycle");
    endtask

    // Skip cases; a taken skip blocks the next cycle
    task automatic t_skip(input emx_op_t op, input logic [7:0] d, input logic [2:0] b,
                          input logic exp);
        issue(op, d, b);
        cmp_bit(skip, exp, "skip decision");
        cmp_bit(op_ready, ~exp, "dummy cycle");
        cmp_flags(6'b011111);
        repeat (EMX_SKIP_BUSY) @(posedge mclk);
        #1;
        cmp_bit(skip, 1'b0, "skip is one pulse");
        cmp_bit(op_ready, 1'b1, "ready after skip");
    endtask

    task automatic t_table(input emx_op_t op, input logic [15:0] w, input logic [15:0] addr,
                           input logic [7:0] tpl);
        issue(op, 8'h00, 3'h0);
        cmp_bit(prog_req, 1'b1, "prog req");
        cmp_val(prog_addr, addr, "prog addr");
        cmp_val(tp_low, tpl, "pointer low");
        cmp_bit(op_ready, 1'b0, "busy");
        @(posedge mclk);
        prog_rdata <= w;
        @(posedge mclk);
        prog_rdata <= ~w;
        #1;
        cmp_bit(mem_we, 1'b1, "table we");
        cmp_val(mem_wdata, w[7:0], "table low");
        cmp_val(tb_latch, w[15:8], "table high");
        cmp_val(mem_addr, 16'h01A5, "table addr");
        cmp_bit(op_ready, 1'b1, "ready after table");
        cmp_flags(6'b011111);
    endtask

    // Watchdog: the whole sequence needs well under 1000 cycles
    initial begin
        #20000;
        err_count++;
        $display("CHECK FAILED t=%0t watchdog expired", $time);
        complete_run();
    end

    initial begin
        err_count  = 0;
        n_checks   = 0;
        rst_n      = 1'b0;
        op_valid   = 1'b0;
        op_code    = EMX_OP_NONE;
        op_addr    = 9'h000;
        bit_sel    = 3'h0;
        mem_rdata  = 8'h00;
        prog_rdata = 16'h0000;
        pc_page    = 6'h15;
        acc_we     = 1'b0;
        acc_wdata  = 8'h00;
        tp_low_we  = 1'b0;
        tp_high_we = 1'b0;
        tp_wdata   = 8'h00;
        repeat (10) @(posedge mclk);
        rst_n <= 1'b1;
        #1;
        cmp_bit(op_ready, 1'b1, "ready after reset");
        cmp_flags(6'b000000);
        cmp_val(accumulator, 16'h0000, "acc reset");
        t_subtract();
        t_swap_xor();
        t_skip(EMX_OP_SKIP_Z, 8'h00, 3'h0, 1'b1);
        t_skip(EMX_OP_SKIP_Z, 8'h80, 3'h0, 1'b0);
        t_skip(EMX_OP_MOV_SKIP_Z, 8'h00, 3'h0, 1'b1);
        cmp_val(accumulator, 16'h0000, "move zero");
        t_skip(EMX_OP_MOV_SKIP_Z, 8'h01, 3'h0, 1'b0);
        cmp_val(accumulator, 16'h0001, "move nonzero");
        t_skip(EMX_OP_SKIP_NZ, 8'h01, 3'h0, 1'b1);
        t_skip(EMX_OP_SKIP_NZ, 8'h00, 3'h0, 1'b0);
        t_skip(EMX_OP_SKIP_BIT_Z, 8'h7F, 3'h7, 1'b1);
        t_skip(EMX_OP_SKIP_BIT_Z, 8'h80, 3'h7, 1'b0);
        t_skip(EMX_OP_SKIP_BIT_Z, 8'hFE, 3'h0, 1'b1);
        load(8'h01, 8'h41, 8'h2B);
        cmp_val(tp_high, 16'h002B, "pointer high");
        t_table(EMX_OP_TRD_CUR, 16'h1234, 16'h1541, 8'h41);
        t_table(EMX_OP_TRD_LAST, 16'hA55A, 16'h3F41, 8'h41);
        t_table(EMX_OP_TRD_INC, 16'h0FF0, 16'h2B42, 8'h42);
        t_table(EMX_OP_TRD_INC_LP, 16'hC003, 16'h3F43, 8'h43);
        load(8'h01, 8'hFF, 8'h2B);
        t_table(EMX_OP_TRD_INC, 16'h8001, 16'h2B00, 8'h00);
        complete_run();
    end
endmodule
